// ===== design/anr_map.vh
// Base page field layout, selector codes, technology codes, register map for the resolver.
// Assumes inclusion by the resolver only.
`ifndef ANR_MAP_VH
`define ANR_MAP_VH
`define ANR_SEL_LSB      0
`define ANR_SEL_W        5
`define ANR_TA_LSB       5
`define ANR_TA_W         8
`define ANR_SEL_ETH      5'h01
`define ANR_SEL_RSV_LO   5'h00
`define ANR_SEL_RSV_HI   5'h1F
`define ANR_A_10HD       0
`define ANR_A_10FD       1
`define ANR_A_TXHD       2
`define ANR_A_TXFD       3
`define ANR_A_T4         4
`define ANR_A_PAUSE      5
`define ANR_A_ASYM       6
`define ANR_A_RSV        7
`define ANR_MSG_W        11
// Resolved technology codes
`define ANR_T_NONE       4'h0
`define ANR_T_1000FD     4'h9
`define ANR_T_1000HD     4'h8
`define ANR_T_T2FD       4'h7
`define ANR_T_TXFD       4'h6
`define ANR_T_T2HD       4'h5
`define ANR_T_T4         4'h4
`define ANR_T_TXHD       4'h3
`define ANR_T_10FD       4'h2
`define ANR_T_10HD       4'h1
// Register byte offsets
`define ANR_R_CTRL       8'h00
`define ANR_R_LOCAL      8'h04
`define ANR_R_PARTNER    8'h08
`define ANR_R_XABIL      8'h0C
`define ANR_R_RESULT     8'h10
`define ANR_R_MSG        8'h14
`define ANR_MSG_RST      11'h001
`endif

// ===== design/anr_resolver.v
// Auto-negotiation base page encoder and link outcome resolver with AHB-Lite registers.
// Assumes one 10 MHz clock, synchronous reset, single-word AHB-Lite transfers.
// Functional notes
// (RULE1) Base page holds a 5-bit binary selector naming the message family.
// (RULE2) Never transmit an unassigned selector, including all-zeros and all-ones.
// (RULE3) Send selector 00001; read ability bits only when received selector is 00001.
// (RULE4) Ability field sits on page bits D5..D12 as A0..A7.
// (RULE5) A0 10T, A1 10T FD, A2 TX, A3 TX FD, A4 T4, A7 reserved.
// (RULE6) Reserved ability bits are always sent as zero.
// (RULE7) A5/A6 sent only when MAC control and pause are implemented.
// (RULE8) Pause pair: 00 none, 01 asym to partner, 10 sym, 11 both.
// (RULE9) Technology priority: 1000FD,1000,T2FD,TXFD,T2,T4,TX,10FD,10.
// (RULE10) Pick the single highest-priority technology common to both ends.
// (RULE11) Vendor technologies may slot in; standard order stays unchanged.
// (RULE12) Pause enables only when resolved technology is full duplex.
// (RULE13) Both symmetric: enable both; local 00 or no asym match: disable both.
// (RULE14) Local 01/partner 11: transmit only; local 11/partner 01: receive only.
// (RULE15) With asym bit set, symmetric bit tells the pause direction.
// (RULE16) Pause bits never affect technology choice.
// (RULE17) A message page precedes any run of unformatted pages.
// (RULE18) Message code is an 11-bit binary value.
// (RULE19) Results registered one cycle after both pages valid, held until renegotiation.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "anr_map.vh"
module anr_resolver #(
  parameter [0:0] MAC_CTRL_PAUSE = 1'b1
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [15:0] tx_base_page,
  output reg  [3:0]  tech_res,
  output reg         pause_tx_en,
  output reg         pause_rx_en,
  output reg         res_valid
);

  // Control, local and partner advertisement, message and address-phase state
  reg        renego_q;
  reg [7:0]  loc_abil_q;
  reg [15:0] lp_page_q;
  reg        lp_valid_q;
  reg        loc_valid_q;
  reg [3:0]  xabil_loc_q;
  reg [3:0]  xabil_lp_q;
  reg [10:0] msg_code_q;
  reg        msg_sent_q;
  reg        unf_err_q;
  reg        ap_wr_q;
  reg [7:0]  ap_addr_q;

  // Next-state values
  reg        renego_d;
  reg [7:0]  loc_abil_d;
  reg [15:0] lp_page_d;
  reg        lp_valid_d;
  reg        loc_valid_d;
  reg [3:0]  xabil_loc_d;
  reg [3:0]  xabil_lp_d;
  reg [10:0] msg_code_d;
  reg        msg_sent_d;
  reg        unf_err_d;
  reg        ap_wr_d;
  reg [7:0]  ap_addr_d;
  reg [31:0] hrdata_d;
  reg [15:0] page_d;
  reg        res_valid_d;
  reg [3:0]  tech_res_d;
  reg        pause_tx_d;
  reg        pause_rx_d;

  wire ap_take = hsel & hready & htrans[1];

  // Priority pick over common abilities; pause bits never enter.
  function [3:0] pick_tech;
    input [7:0] la;
    input [7:0] pa;
    input [3:0] lx;
    input [3:0] px;
    reg   [7:0] c;
    reg   [3:0] x;
    begin
      c = la & pa;
      x = lx & px;
      if (x[3])                         pick_tech = `ANR_T_1000FD; // RULE9
      else if (x[2])                    pick_tech = `ANR_T_1000HD;
      else if (x[1])                    pick_tech = `ANR_T_T2FD;
      else if (c[`ANR_A_TXFD])          pick_tech = `ANR_T_TXFD;
      else if (x[0])                    pick_tech = `ANR_T_T2HD;
      else if (c[`ANR_A_T4])            pick_tech = `ANR_T_T4;
      else if (c[`ANR_A_TXHD])          pick_tech = `ANR_T_TXHD;
      else if (c[`ANR_A_10FD])          pick_tech = `ANR_T_10FD;
      else if (c[`ANR_A_10HD])          pick_tech = `ANR_T_10HD;
      else                              pick_tech = `ANR_T_NONE; // RULE10 RULE11
    end
  endfunction

  function is_fd;
    input [3:0] t;
    begin
      is_fd = (t == `ANR_T_1000FD) | (t == `ANR_T_T2FD) |
              (t == `ANR_T_TXFD) | (t == `ANR_T_10FD);
    end
  endfunction

  // Transmitted ability: reserved zero, pause bits gated by capability
  wire [7:0] loc_tx_abil = {1'b0,                                       // RULE6
                            loc_abil_q[`ANR_A_ASYM] & MAC_CTRL_PAUSE,   // RULE7
                            loc_abil_q[`ANR_A_PAUSE] & MAC_CTRL_PAUSE,
                            loc_abil_q[4:0]};                           // RULE5

  // Partner base page abilities ignored unless its selector is the Ethernet one
  wire       lp_eth     = lp_page_q[`ANR_SEL_LSB +: `ANR_SEL_W] == `ANR_SEL_ETH; // RULE3
  wire [7:0] lp_abil    = lp_eth ? lp_page_q[`ANR_TA_LSB +: `ANR_TA_W] : 8'h00;  // RULE4
  wire [3:0] tech_d     = pick_tech(loc_tx_abil, lp_abil, xabil_loc_q, xabil_lp_q); // RULE16

  // Pause resolution
  wire lps = lp_abil[`ANR_A_PAUSE];
  wire lpa = lp_abil[`ANR_A_ASYM];
  wire ls  = loc_tx_abil[`ANR_A_PAUSE];
  wire la  = loc_tx_abil[`ANR_A_ASYM];
  wire sym_both = ls & lps;                    // RULE13 RULE8
  wire tx_only  = ~ls & la & lps & lpa;        // RULE14 RULE15
  wire rx_only  = ls & la & ~lps & lpa;        // RULE14 RULE15
  wire fd       = is_fd(tech_d);

  // Address phase capture; the data phase acts one edge later
  always @* begin
    ap_wr_d   = ap_take & hwrite;
    ap_addr_d = ap_addr_q;
    if (ap_take) begin
      ap_addr_d = haddr[7:0];
    end
  end

  // Read word launched at the address phase, standing in the data phase
  always @* begin
    hrdata_d = hrdata;
    if (ap_take & ~hwrite) begin
      case (haddr[7:0])
        `ANR_R_CTRL: begin
          hrdata_d = {26'h0, unf_err_q, msg_sent_q, 1'b0,
                      lp_valid_q, loc_valid_q, 1'b0};
        end
        `ANR_R_LOCAL: begin
          hrdata_d = {24'h0, loc_abil_q};
        end
        `ANR_R_PARTNER: begin
          hrdata_d = {16'h0, lp_page_q};
        end
        `ANR_R_XABIL: begin
          hrdata_d = {24'h0, xabil_lp_q, xabil_loc_q};
        end
        `ANR_R_RESULT: begin
          hrdata_d = {24'h0, pause_rx_en, pause_tx_en, res_valid,
                      1'b0, tech_res};
        end
        `ANR_R_MSG: begin
          hrdata_d = {21'h0, msg_code_q};
        end
        default: begin
          hrdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // Data phase register writes
  always @* begin
    renego_d    = 1'b0;
    loc_valid_d = loc_valid_q;
    lp_valid_d  = lp_valid_q;
    msg_sent_d  = msg_sent_q;
    unf_err_d   = unf_err_q;
    loc_abil_d  = loc_abil_q;
    lp_page_d   = lp_page_q;
    xabil_loc_d = xabil_loc_q;
    xabil_lp_d  = xabil_lp_q;
    msg_code_d  = msg_code_q;
    if (ap_wr_q) begin
      case (ap_addr_q)
        `ANR_R_CTRL: begin
          renego_d    = hwdata[0];
          loc_valid_d = hwdata[1];
          lp_valid_d  = hwdata[2];
          if (hwdata[3]) begin
            msg_sent_d = 1'b1;
          end
          if (hwdata[4]) begin
            unf_err_d = ~msg_sent_q; // RULE17
          end
        end
        `ANR_R_LOCAL: begin
          loc_abil_d = hwdata[7:0];
        end
        `ANR_R_PARTNER: begin
          lp_page_d = hwdata[15:0];
        end
        `ANR_R_XABIL: begin
          xabil_loc_d = hwdata[3:0];
          xabil_lp_d  = hwdata[7:4];
        end
        `ANR_R_MSG: begin
          msg_code_d = hwdata[`ANR_MSG_W-1:0]; // RULE18
          msg_sent_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Pending renegotiation wins over a partner valid write
    if (renego_q) begin
      lp_valid_d = 1'b0;
    end
  end

  // Resolution: taken once, held until renegotiation
  always @* begin
    res_valid_d = res_valid;
    tech_res_d  = tech_res;
    pause_tx_d  = pause_tx_en;
    pause_rx_d  = pause_rx_en;
    if (renego_q) begin
      res_valid_d = 1'b0;
      tech_res_d  = `ANR_T_NONE;
      pause_tx_d  = 1'b0;
      pause_rx_d  = 1'b0;
    end else if (loc_valid_q & lp_valid_q & ~res_valid) begin // RULE19
      res_valid_d = 1'b1;
      tech_res_d  = tech_d;
      pause_tx_d  = fd & (sym_both | tx_only); // RULE12
      pause_rx_d  = fd & (sym_both | rx_only); // RULE12
    end
  end

  // Outgoing base page: fixed Ethernet selector, never reserved codes
  always @* begin
    page_d = {3'b000, loc_tx_abil, `ANR_SEL_ETH}; // RULE1 RULE2 RULE3 RULE4
  end

  // State registers; bus answer is always ready and OKAY
  always @(posedge mclk) begin
    if (srst) begin
      hrdata       <= 32'h00000000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      tx_base_page <= 16'h0000;
      tech_res     <= `ANR_T_NONE;
      pause_tx_en  <= 1'b0;
      pause_rx_en  <= 1'b0;
      res_valid    <= 1'b0;
      renego_q     <= 1'b0;
      loc_abil_q   <= 8'h00;
      lp_page_q    <= 16'h0000;
      lp_valid_q   <= 1'b0;
      loc_valid_q  <= 1'b0;
      xabil_loc_q  <= 4'h0;
      xabil_lp_q   <= 4'h0;
      msg_code_q   <= `ANR_MSG_RST;
      msg_sent_q   <= 1'b0;
      unf_err_q    <= 1'b0;
      ap_wr_q      <= 1'b0;
      ap_addr_q    <= 8'h00;
    end else begin
      hrdata       <= hrdata_d;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      tx_base_page <= page_d;
      tech_res     <= tech_res_d;
      pause_tx_en  <= pause_tx_d;
      pause_rx_en  <= pause_rx_d;
      res_valid    <= res_valid_d;
      renego_q     <= renego_d;
      loc_abil_q   <= loc_abil_d;
      lp_page_q    <= lp_page_d;
      lp_valid_q   <= lp_valid_d;
      loc_valid_q  <= loc_valid_d;
      xabil_loc_q  <= xabil_loc_d;
      xabil_lp_q   <= xabil_lp_d;
      msg_code_q   <= msg_code_d;
      msg_sent_q   <= msg_sent_d;
      unf_err_q    <= unf_err_d;
      ap_wr_q      <= ap_wr_d;
      ap_addr_q    <= ap_addr_d;
    end
  end

endmodule
`default_nettype wire

// ===== test/anr_lp.sv
// Link partner model: forms the partner's received base page.
// Assumes the bench copies the page into the partner register.
`timescale 1ns/1ps
`default_nettype none
module anr_lp (
  input  wire logic [6:0]  abil,
  input  wire logic        bad_sel,
  output logic      [15:0] page
);
  // Abilities on D5..D11, A7 zero, assigned selector only
  assign page = {4'h0, abil, bad_sel ? 5'h02 : 5'h01};
endmodule
`default_nettype wire

// ===== test/anr_resolver_assertions.sv
// Checker on the resolver's page and result outputs.
// Assumes a bind from the bench's top file.
`timescale 1ns/1ps
`default_nettype none
module anr_chk (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [15:0] tx_base_page,
  input wire logic [3:0]  tech_res,
  input wire logic        pause_tx_en,
  input wire logic        pause_rx_en,
  input wire logic        res_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  AST_SEL: assert property (!$past(srst) |-> tx_base_page[4:0] == 5'h01)
    else $error("selector wrong");
  AST_TOP: assert property (!$past(srst) |-> tx_base_page[15:13] == 3'h0)
    else $error("page top bits set");
  AST_A7: assert property (!$past(srst) |-> !tx_base_page[12])
    else $error("reserved ability set");
  AST_HOLD: assert property (res_valid && $past(res_valid) |->
    $stable(tech_res) && $stable({pause_tx_en, pause_rx_en})) else $error("result moved");
  AST_FD: assert property (pause_tx_en || pause_rx_en |->
    tech_res inside {4'h9, 4'h7, 4'h6, 4'h2}) else $error("pause on half duplex");
  AST_IDLE: assert property (!res_valid |-> tech_res == 4'h0 && !pause_tx_en && !pause_rx_en)
    else $error("result without valid");
  AST_RNG: assert property (res_valid |-> tech_res <= 4'h9)
    else $error("bad tech code");
  AST_STEP: assert property ($rose(res_valid) |-> $past(tech_res) == 4'h0 && !$past(pause_rx_en))
    else $error("result ahead of valid");
endmodule
`default_nettype wire

// ===== test/tb.sv
// Bench: AHB-Lite tasks run negotiation cases through the resolver.
// Assumes the partner model supplies received pages.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'h0, srst = 1'h1, hwrite = 1'h0, bad = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp, ptx, prx, rv;
  logic [15:0] txp, pg;
  logic [3:0]  tech;
  logic [6:0]  pab = 7'h0;
  int          failures = 0, n_tests = 0, cyc = 0;
  anr_resolver dut_u (.mclk, .srst, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hsel(1'h1), .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_base_page(txp),
    .tech_res(tech), .pause_tx_en(ptx), .pause_rx_en(prx), .res_valid(rv));
  anr_lp lp_u (.abil(pab), .bad_sel(bad), .page(pg));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  // x is {partner, local} gigabit and T2 abilities
  task automatic cs(input logic [7:0] la, pa, x, input logic b, input logic [7:0] e);
    pab <= pa[6:0];
    bad <= b;
    xfer(8'h00, 1'b1, 32'h1);
    xfer(8'h04, 1'b1, {24'h0, la});
    xfer(8'h0C, 1'b1, {24'h0, x});
    xfer(8'h08, 1'b1, {16'h0, pg});
    xfer(8'h00, 1'b1, 32'h6);
    repeat (3) @(posedge mclk);
    xfer(8'h10, 1'b0, 32'h0);
    chk(rd & 32'hEF, {24'h0, e});
    chk({24'h0, prx, ptx, rv, 1'b0, tech}, {24'h0, e});
    chk({31'h0, hresp}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'h0;
    @(posedge mclk);
    xfer(8'h14, 1'b0, 32'h0);
    chk(rd, 32'h1);
    chk({16'h0, txp}, 32'h1);
    xfer(8'h40, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(8'h04, 1'b1, 32'hFF);
    xfer(8'h04, 1'b0, 32'h0);
    chk(rd, 32'hFF);
    repeat (2) @(posedge mclk);
    chk({16'h0, txp}, 32'h0FE1);
    xfer(8'h14, 1'b1, 32'h8);
    xfer(8'h00, 1'b1, 32'h10);
    xfer(8'h00, 1'b0, 32'h0);
    chk(rd & 32'h20, 32'h20);
    cs(8'h3F, 8'h3F, 8'h00, 1'b0, 8'hE6);
    cs(8'h34, 8'h35, 8'h00, 1'b0, 8'h24);
    cs(8'h1F, 8'h1F, 8'h8F, 1'b0, 8'h29);
    cs(8'h48, 8'h68, 8'h22, 1'b0, 8'h67);
    cs(8'h62, 8'h42, 8'h00, 1'b0, 8'hA2);
    cs(8'h02, 8'h62, 8'h00, 1'b0, 8'h22);
    cs(8'h42, 8'h22, 8'h00, 1'b0, 8'h22);
    cs(8'h3F, 8'h3F, 8'h00, 1'b1, 8'h20);
    cs(8'h04, 8'h04, 8'h11, 1'b0, 8'h25);
    cs(8'h01, 8'h01, 8'h00, 1'b0, 8'h21);
    print_verdict;
  end
endmodule
bind anr_resolver anr_chk chk_u (.mclk, .srst, .tx_base_page, .tech_res, .pause_tx_en,
  .pause_rx_en, .res_valid);
`default_nettype wire
